// ### hw/ext_int_pkg.sv
// Constants shared by the external request line conditioner and its line slices.
// Assumes an 8-bit special-function register port with one-cycle read latency.
package ext_int_pkg;

   // Configuration register address and its value after reset.
   localparam logic [7:0] CFG_ADDR        = 8'hE4;
   localparam logic [7:0] CFG_RESET       = 8'h01;

   // Configuration field positions, per line: select at 4*line, polarity at 4*line+3.
   localparam int         CFG_LINE_STRIDE = 4;
   localparam int         CFG_POL_OFS     = 3;

   // Timer control register: default address and the bits owned by this block.
   localparam logic [7:0] TC_ADDR_DEFAULT = 8'h88;
   localparam logic [7:0] TC_RESET        = 8'h00;
   localparam int         TC_EDGE_A       = 0;
   localparam int         TC_PEND_A       = 1;
   localparam int         TC_EDGE_B       = 2;
   localparam int         TC_PEND_B       = 3;

   // Structure sizes.
   localparam int         NUM_LINES       = 2;
   localparam int         PORT_WIDTH      = 8;
   localparam int         SEL_WIDTH       = 3;

   // Value the pin synchroniser holds during reset, an idle pulled-up port.
   localparam logic [7:0] PINS_IDLE       = 8'hFF;
   localparam logic [7:0] RDATA_RESET     = 8'h00;

endpackage : ext_int_pkg

// ### hw/line_cfg_if.sv
// Carrier between the register front end and one line conditioner slice.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface line_cfg_if;
   logic       polarity;
   logic [2:0] pin_select;
   logic       edge_mode;
   logic [7:0] pins;
   logic       vector_ack;
   logic       flag_wr;
   logic       flag_wval;
   logic       pending;

   modport ctrl (output polarity, output pin_select, output edge_mode, output pins,
                 output vector_ack, output flag_wr, output flag_wval, input pending);
   modport cond (input polarity, input pin_select, input edge_mode, input pins,
                 input vector_ack, input flag_wr, input flag_wval, output pending);
endinterface : line_cfg_if

// ### hw/line_conditioner.sv
// One external request line: pin select, polarity, edge or level sense, pending flag.
// Assumes pins are already synchronised and reset is released synchronously.
`timescale 1ns/1ps
module line_conditioner
   import ext_int_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   line_cfg_if.cond  cfg
);

   typedef struct packed {
      logic active_prev;
      logic pending;
   } cond_state_type;

   cond_state_type s_q;
   cond_state_type s_d;
   logic           sel_pin;
   logic           active;
   logic           rise;

   // Pin choice and polarity are combinational so a config write takes effect next cycle.
   always_comb begin
      // [RL3] Pin select mux.
      sel_pin = cfg.pins[cfg.pin_select];
      // [RL1] Polarity inversion.
      active  = cfg.polarity ? sel_pin : ~sel_pin;
      rise    = active & ~s_q.active_prev;
      s_d     = s_q;
      s_d.active_prev = active;
      // [RL2] Edge versus level.
      if (cfg.edge_mode) begin
         // [RL8] Vectoring clears flag.
         if (cfg.vector_ack) begin
            s_d.pending = 1'b0;
         end
         if (cfg.flag_wr) begin
            s_d.pending = cfg.flag_wval;
         end
         // [RL12] Edge sets flag; the set beats any clear in the same cycle.
         if (rise) begin
            s_d.pending = 1'b1;
         end
      end else begin
         // [RL9] Level follows input.
         s_d.pending = active;
      end
   end

   // Previous level resets high so an input already active at reset is not taken as an edge.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q.active_prev <= 1'b1;
         s_q.pending     <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg.pending = s_q.pending;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_level_follows;
      !cfg.edge_mode |=> cfg.pending == $past(active);
   endproperty
   a_level_follows: assert property (p_level_follows) else $error("level flag did not follow input"); // [RL9]

   property p_edge_sets;
      cfg.edge_mode && active && !s_q.active_prev |=> cfg.pending;
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("edge did not set pending"); // [RL12]

   property p_ack_clears;
      cfg.edge_mode && cfg.vector_ack && !cfg.flag_wr && !rise |=> !cfg.pending;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear pending"); // [RL8]

   property p_edge_holds;
      cfg.edge_mode && !cfg.vector_ack && !cfg.flag_wr && !rise |=> $stable(cfg.pending);
   endproperty
   a_edge_holds: assert property (p_edge_holds) else $error("edge flag changed without cause"); // [RL2]

   property p_active_low;
      !cfg.edge_mode && !cfg.polarity && !cfg.pins[cfg.pin_select] |=> cfg.pending;
   endproperty
   a_active_low: assert property (p_active_low) else $error("low input not active at polarity 0"); // [RL1]

   property p_pin_select;
      !cfg.edge_mode && cfg.polarity |=> cfg.pending == $past(cfg.pins[cfg.pin_select]);
   endproperty
   a_pin_select: assert property (p_pin_select) else $error("wrong pin monitored"); // [RL3]

endmodule : line_conditioner

// ### hw/ext_interrupt_pin_conditioner.sv
// Top of the external request line conditioner: register port, pin synchroniser, two lines.
// Assumes the core drives an 8-bit register port and one vectoring pulse per line.
// Notes on behaviour
// [RL1] Polarity 0 means active low, 1 high.
// [RL2] Sense bit 1 edges, 0 levels.
// [RL3] Three-bit code picks port pin 0 to 7.
// [RL4] Config bits: b polarity, b select, a polarity, a select.
// [RL5] Config at 0xE4, all pages, resets 0x01.
// [RL6] Pins only observed, never driven.
// [RL7] Pending flags in timer control bits 1, 3.
// [RL8] Edge mode: vectoring clears pending flag.
// [RL9] Level mode: flag mirrors active input.
// [RL10] Requester holds level until request recognised.
// [RL11] Requester drops level before routine ends.
// [RL12] Edge sets flag until vectored or written.
`timescale 1ns/1ps
module ext_interrupt_pin_conditioner
   import ext_int_pkg::*;
#(
   parameter logic [7:0] TC_ADDR = TC_ADDR_DEFAULT
)
(
   input  wire  logic                  clk_sys,
   input  wire  logic                  arst_n,
   input  wire  logic [PORT_WIDTH-1:0] port0_pins,
   input  wire  logic [7:0]            sfr_addr,
   input  wire  logic                  sfr_wr,
   input  wire  logic                  sfr_rd,
   input  wire  logic [7:0]            sfr_wdata,
   output logic       [7:0]            sfr_rdata,
   input  wire  logic                  vector_ack_a,
   input  wire  logic                  vector_ack_b,
   output logic                        line_a_pending,
   output logic                        line_b_pending
);

   typedef struct packed {
      logic [PORT_WIDTH-1:0] sync1;
      logic [PORT_WIDTH-1:0] sync2;
      logic [PORT_WIDTH-1:0] sync3;
      logic [PORT_WIDTH-1:0] pins_filt;
      logic [7:0]            cfg;
      logic [NUM_LINES-1:0]  edge_mode;
      logic [7:0]            rdata;
   } top_state_type;

   top_state_type        s_q;
   top_state_type        s_d;
   logic [1:0]           rst_sync_q;
   logic                 rst_n;
   logic [NUM_LINES-1:0] pend;
   logic [NUM_LINES-1:0] ack;
   logic                 cfg_hit_wr;
   logic                 tc_hit_wr;

   // Register decode ignores the page, since both registers are visible on all pages.
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction : addr_hit

   // Reset release is synchronised so both slices leave reset on the same edge.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Decoded strobes, shared by the register update and the slices.
   assign ack        = {vector_ack_b, vector_ack_a};
   assign cfg_hit_wr = sfr_wr && addr_hit(sfr_addr, CFG_ADDR);
   assign tc_hit_wr  = sfr_wr && addr_hit(sfr_addr, TC_ADDR);

   // Next state: synchroniser, register writes and registered read data.
   always_comb begin
      s_d = s_q;
      // [RL6] Pins sampled only.
      s_d.sync1 = port0_pins;
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      // A bit moves only once two stages agree, which rejects a one-cycle glitch at the pins.
      for (int i = 0; i < PORT_WIDTH; i++) begin
         if (s_q.sync2[i] == s_q.sync3[i]) begin
            s_d.pins_filt[i] = s_q.sync3[i];
         end
      end
      // [RL4] Config write.
      if (cfg_hit_wr) begin
         s_d.cfg = sfr_wdata;
      end
      // [RL2] Sense bits written.
      if (tc_hit_wr) begin
         s_d.edge_mode = {sfr_wdata[TC_EDGE_B], sfr_wdata[TC_EDGE_A]};
      end
      // Unmapped addresses read as zero; reads have no side effects.
      if (sfr_rd) begin
         s_d.rdata = RDATA_RESET;
         // [RL5] Config readback.
         if (addr_hit(sfr_addr, CFG_ADDR)) begin
            s_d.rdata = s_q.cfg;
         end else if (addr_hit(sfr_addr, TC_ADDR)) begin
            // [RL7] Pending flag positions.
            s_d.rdata[TC_EDGE_A] = s_q.edge_mode[0];
            s_d.rdata[TC_PEND_A] = pend[0];
            s_d.rdata[TC_EDGE_B] = s_q.edge_mode[1];
            s_d.rdata[TC_PEND_B] = pend[1];
         end
      end
   end

   // Single register stage for all top state except the reset synchroniser.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q.sync1     <= PINS_IDLE;
         s_q.sync2     <= PINS_IDLE;
         s_q.sync3     <= PINS_IDLE;
         s_q.pins_filt <= PINS_IDLE;
         // [RL5] Config reset value.
         s_q.cfg       <= CFG_RESET;
         s_q.edge_mode <= {TC_RESET[TC_EDGE_B], TC_RESET[TC_EDGE_A]};
         s_q.rdata     <= RDATA_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // One conditioner slice per request line, fed from the config fields of that line.
   for (genvar ln = 0; ln < NUM_LINES; ln++) begin : g_line
      line_cfg_if lif ();
      assign lif.polarity   = s_q.cfg[CFG_LINE_STRIDE*ln+CFG_POL_OFS];
      assign lif.pin_select = s_q.cfg[CFG_LINE_STRIDE*ln +: SEL_WIDTH];
      assign lif.edge_mode  = s_q.edge_mode[ln];
      assign lif.pins       = s_q.pins_filt;
      assign lif.vector_ack = ack[ln];
      assign lif.flag_wr    = tc_hit_wr;
      // [RL7] Write value lane.
      assign lif.flag_wval  = (ln == 0) ? sfr_wdata[TC_PEND_A] : sfr_wdata[TC_PEND_B];
      assign pend[ln]       = lif.pending;
      line_conditioner u_cond (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .cfg     (lif)
      );
   end

   // Outputs come straight from the registered read data and the slice flags.
   assign sfr_rdata      = s_q.rdata;
   assign line_a_pending = pend[0];
   assign line_b_pending = pend[1];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_cfg_reset;
      $rose(rst_n) |-> s_q.cfg == CFG_RESET && s_q.edge_mode == 2'b00;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config not at reset value"); // [RL5]

   property p_cfg_fields;
      cfg_hit_wr |=> g_line[0].lif.polarity == $past(sfr_wdata[3])
                  && g_line[0].lif.pin_select == $past(sfr_wdata[2:0])
                  && g_line[1].lif.polarity == $past(sfr_wdata[7])
                  && g_line[1].lif.pin_select == $past(sfr_wdata[6:4]);
   endproperty
   a_cfg_fields: assert property (p_cfg_fields) else $error("config field layout wrong"); // [RL4]

   property p_tc_read;
      sfr_rd && addr_hit(sfr_addr, TC_ADDR) |=> sfr_rdata[1] == $past(line_a_pending)
                                             && sfr_rdata[3] == $past(line_b_pending)
                                             && sfr_rdata[7:4] == 4'h0;
   endproperty
   a_tc_read: assert property (p_tc_read) else $error("pending flags misplaced in readback"); // [RL7]

   property p_cfg_read;
      ##1 sfr_rd && addr_hit(sfr_addr, CFG_ADDR) && !$past(cfg_hit_wr) |=> sfr_rdata == $past(s_q.cfg);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong"); // [RL5]

   // Register port checks: writes land whole, reads of other addresses are empty,
   // and read data stands until the next read so a slow master can still take it.
   property p_cfg_write;
      cfg_hit_wr |=> s_q.cfg == $past(sfr_wdata);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [RL4]

   property p_cfg_hold;
      !cfg_hit_wr |=> $stable(s_q.cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // [RL4]

   property p_sense_write;
      tc_hit_wr |=> s_q.edge_mode == $past({sfr_wdata[TC_EDGE_B], sfr_wdata[TC_EDGE_A]});
   endproperty
   a_sense_write: assert property (p_sense_write) else $error("sense bits not written"); // [RL2]

   property p_sense_read;
      sfr_rd && addr_hit(sfr_addr, TC_ADDR) |=> sfr_rdata[TC_EDGE_A] == $past(s_q.edge_mode[0])
                                             && sfr_rdata[TC_EDGE_B] == $past(s_q.edge_mode[1]);
   endproperty
   a_sense_read: assert property (p_sense_read) else $error("sense bits misplaced in readback"); // [RL2]

   property p_unmapped_read;
      sfr_rd && !addr_hit(sfr_addr, CFG_ADDR) && !addr_hit(sfr_addr, TC_ADDR)
         |=> sfr_rdata == RDATA_RESET;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RL5]

   property p_rdata_holds;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read"); // [RL7]

   property p_filter_agree;
      s_q.sync2 == s_q.sync3 |=> s_q.pins_filt == $past(s_q.sync3);
   endproperty
   a_filter_agree: assert property (p_filter_agree) else $error("filtered pins not updated"); // [RL6]

   property p_out_reset;
      $rose(rst_n) |-> sfr_rdata == RDATA_RESET && !line_a_pending && !line_b_pending;
   endproperty
   a_out_reset: assert property (p_out_reset) else $error("outputs not at reset value"); // [RL5]

endmodule : ext_interrupt_pin_conditioner

// ### test/pin_source.sv
// Model of the external request sources wired to port 0.
// Assumes the bench sets wanted pin levels just after a rising edge.
`timescale 1ns/1ps
module pin_source (
   input  wire logic       clk_sys,
   input  wire logic [7:0] level_req,
   output logic      [7:0] pins
);
   // Levels move only on the clock, and the bench keeps a level until it has seen the flag.
   // Hold then drop.
   always_ff @(posedge clk_sys) begin
      pins <= level_req;
   end
endmodule : pin_source

// ### test/tb.sv
// Self-checking bench for the external request line conditioner.
// Assumes the pin source model and a register port with one-cycle read latency.
`timescale 1ns/1ps
module tb
   import ext_int_pkg::*;
;
   logic        clk_sys   = 1'b0;
   logic        arst_n    = 1'b0;
   logic        sfr_wr    = 1'b0;
   logic        sfr_rd    = 1'b0;
   logic        ack_a     = 1'b0;
   logic        ack_b     = 1'b0;
   logic [7:0]  sfr_addr  = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  level_req = 8'hFF;
   logic [7:0]  pins;
   logic [7:0]  sfr_rdata;
   logic        pend_a;
   logic        pend_b;
   logic [31:0] seed      = 32'h8B90;
   int          failures  = 0;
   int          total_checks = 0;

   // The clock toggles every half period of 12.5 ns.
   always #12.5 clk_sys = ~clk_sys;

   pin_source i_src (.clk_sys(clk_sys), .level_req(level_req), .pins(pins));

   ext_interrupt_pin_conditioner #(.TC_ADDR(TC_ADDR_DEFAULT)) i_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .port0_pins(pins), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .vector_ack_a(ack_a), .vector_ack_b(ack_b),
      .line_a_pending(pend_a), .line_b_pending(pend_b));

   // Repeatable random numbers for pin patterns; configurations come from the loop count.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // Whether a line sees its selected pin at the active level.
   function automatic logic act(input logic [7:0] cfg, input logic [7:0] p, input int l);
      return p[cfg[CFG_LINE_STRIDE*l +: 3]] == cfg[CFG_LINE_STRIDE*l+CFG_POL_OFS];
   endfunction : act

   task automatic give_verdict;
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Every driver change lands 2 ns after a rising edge.
   task automatic step;
      @(posedge clk_sys);
      #2;
   endtask : step

   // The strobe stays low for a full cycle, so back-to-back calls never drive it twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      step();
      sfr_wr    = 1'b0;
      step();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      step();
      sfr_rd   = 1'b0;
      step();
      chk(sfr_rdata, exp);
   endtask : rd

   // A level request reaches the flag six edges later, so eight steps cover it; a fixed wait
   // keeps an early match with the old flags from hiding a change that has not arrived yet.
   task automatic wait_pend(input logic ea, input logic eb);
      repeat (8) step();
      chk({6'h00, pend_a, pend_b}, {6'h00, ea, eb});
   endtask : wait_pend

   task automatic pulse_ack(input logic a, input logic b);
      ack_a = a;
      ack_b = b;
      step();
      ack_a = 1'b0;
      ack_b = 1'b0;
      step();
   endtask : pulse_ack

   // A run that stalls still ends through the verdict, with the stall counted.
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end

   // Main sequence: reset values, level sense over all selects, then edge sense.
   initial begin
      int         i;
      logic [7:0] cfg;
      logic [7:0] p;
      repeat (20) @(posedge clk_sys);
      #2;
      arst_n = 1'b1;
      repeat (3) step();
      rd(CFG_ADDR, CFG_RESET);
      rd(TC_ADDR_DEFAULT, TC_RESET);
      rd(8'h3C, RDATA_RESET);
      wait_pend(1'b0, 1'b0);
      for (i = 0; i < 32; i++) begin
         seed     = xs(seed);
         cfg      = {i[4], ~i[2:0], i[3], i[2:0]};
         p        = seed[15:8];
         wr(CFG_ADDR, cfg);
         rd(CFG_ADDR, cfg);
         level_req = p;
         wait_pend(act(cfg, p, 0), act(cfg, p, 1));
         level_req = ~p;
         wait_pend(act(cfg, ~p, 0), act(cfg, ~p, 1));
      end
      // Line a on pin 2 active high, line b on pin 5 active low.
      level_req = 8'h20;
      wr(CFG_ADDR, 8'h5A);
      wait_pend(1'b0, 1'b0);
      wr(TC_ADDR_DEFAULT, 8'h05);
      rd(TC_ADDR_DEFAULT, 8'h05);
      level_req = 8'h04;
      wait_pend(1'b1, 1'b1);
      rd(TC_ADDR_DEFAULT, 8'h0F);
      level_req = 8'h20;
      repeat (8) step();
      chk({6'h00, pend_a, pend_b}, 8'h03);
      pulse_ack(1'b1, 1'b0);
      wait_pend(1'b0, 1'b1);
      pulse_ack(1'b0, 1'b1);
      wait_pend(1'b0, 1'b0);
      wr(TC_ADDR_DEFAULT, 8'h0F);
      wait_pend(1'b1, 1'b1);
      wr(TC_ADDR_DEFAULT, 8'h07);
      wait_pend(1'b1, 1'b0);
      rd(TC_ADDR_DEFAULT, 8'h07);
      give_verdict();
   end
endmodule : tb
